//--- pbsg_top.sv
// pci port: bus signalling, master and target engines, grant handling
//
// Operation
// - internal arbiter drives four active-low grants to tell an agent it owns bus.
// - host mode with external arbiter: grant zero is an input from that arbiter.
// - satellite mode: grant zero is an input from the external arbiter.
// - without internal arbiter, grant lines one to three are driven high.
// - master puts address on the muxed bus in the first frame cycle, then write data.
// - master drives command first, then byte enables on the same four lines.
// - master asserts frame to start and negates it for the last data phase.
// - target asserts device select after decoding an address of its own.
// - master asserts initiator ready when it can complete the current word.
// - all bus signals are sampled and driven on the bus clock.
// - names ending in n, and the reset rst_b_in, are active low; everything else is active high.
// - with internal arbiter, the four request lines are inputs from agents.
// - addressed target asserts target ready when it can complete the word.
// - target asserts stop to end a transaction early, such as retry.
`timescale 1ns/100ps
module pbsg_top (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // bus clock and strap
  input wire logic bus_clock_in,
  input wire logic [1:0] bus_mode_in,
  // address, data and command pins
  input wire logic [31:0] muxed_addr_data_in,
  output logic [31:0] muxed_addr_data_out,
  output logic muxed_addr_data_oe_n_out,
  input wire logic [3:0] command_byte_enable_n_in,
  output logic [3:0] command_byte_enable_n_out,
  output logic command_byte_enable_oe_n_out,
  // control pins
  input wire logic transaction_frame_n_in,
  output logic transaction_frame_n_out,
  output logic transaction_frame_oe_n_out,
  input wire logic initiator_ready_n_in,
  output logic initiator_ready_n_out,
  output logic initiator_ready_oe_n_out,
  input wire logic target_ready_n_in,
  output logic target_ready_n_out,
  output logic target_ready_oe_n_out,
  input wire logic target_select_n_in,
  output logic target_select_n_out,
  output logic target_select_oe_n_out,
  input wire logic target_stop_n_in,
  output logic target_stop_n_out,
  output logic target_stop_oe_n_out,
  // arbitration pins
  input wire logic [3:0] bus_grant_n_in,
  output logic [3:0] bus_grant_n_out,
  output logic [3:0] bus_grant_oe_n_out,
  input wire logic [3:0] bus_request_n_in,
  output logic [3:0] bus_request_n_out,
  output logic [3:0] bus_request_oe_n_out,
  // master user port
  input wire logic mst_start_in,
  input wire logic mst_write_in,
  input wire logic [31:0] mst_addr_in,
  input wire logic [31:0] mst_wdata_in,
  input wire logic [3:0] mst_be_n_in,
  output logic mst_busy_out,
  output logic mst_done_out,
  output logic mst_retry_out,
  output logic mst_abort_out,
  output logic [31:0] mst_rdata_out,
  // target user port
  input wire logic [31:0] tgt_base_in,
  input wire logic [31:0] tgt_mask_in,
  input wire logic tgt_ready_in,
  input wire logic [31:0] tgt_rdata_in,
  output logic tgt_write_out,
  output logic tgt_read_out,
  output logic [31:0] tgt_addr_out,
  output logic [31:0] tgt_wdata_out,
  output logic [3:0] tgt_be_n_out
);
  import pbsg_pkg::*;

  pbsg_state_type st;
  pbsg_state_type next_st;
  pbsg_pins_type pins_now;
  pbsg_pins_type p;
  logic rise;
  logic bus_idle;
  logic hit_now;
  logic addr_phase;
  logic mode_int;

  assign pins_now = '{mode: bus_mode_in, ad: muxed_addr_data_in,
    cbe_n: command_byte_enable_n_in, frame_n: transaction_frame_n_in,
    irdy_n: initiator_ready_n_in, trdy_n: target_ready_n_in,
    devsel_n: target_select_n_in, stop_n: target_stop_n_in,
    gnt_n: bus_grant_n_in, req_n: bus_request_n_in};
  assign p = st.sync2;
  assign rise = st.clk_sh[1] & ~st.clk_sh[2];
  assign bus_idle = p.frame_n & p.irdy_n;
  assign mode_int = (p.mode == MODE_HOST_INT);
  assign addr_phase = ~p.frame_n & st.last_frame_n;
  assign hit_now = addr_phase && st.mst == M_IDLE
    && ((p.ad & tgt_mask_in) == (tgt_base_in & tgt_mask_in))
    && (p.cbe_n == CMD_MEM_READ || p.cbe_n == CMD_MEM_WRITE);

  // ==========================================
  // next state
  always_comb begin
    logic [4:0] reqs;
    logic [3:0] slot;
    logic found;
    logic granted;
    logic xfer;
    reqs = {st.mst == M_REQ, ~p.req_n};
    slot = 4'h0;
    found = 1'b0;
    granted = 1'b0;
    xfer = 1'b0;
    next_st = st;
    next_st.sync1 = pins_now;
    next_st.sync2 = st.sync1;
    next_st.clk_sh = {st.clk_sh[1:0], bus_clock_in};
    next_st.m_done = 1'b0;
    next_st.t_wr_pulse = 1'b0;
    next_st.t_rd_pulse = 1'b0;
    if (mst_start_in && st.mst == M_IDLE) begin
      next_st.mst = M_REQ;
      next_st.m_addr = mst_addr_in;
      next_st.m_data = mst_wdata_in;
      next_st.m_be_n = mst_be_n_in;
      next_st.m_write = mst_write_in;
      next_st.m_cmd = mst_write_in ? CMD_MEM_WRITE : CMD_MEM_READ;
      next_st.m_retry = 1'b0;
      next_st.m_abort = 1'b0;
    end
    if (rise) begin
      next_st.last_frame_n = p.frame_n;
      // ==========================================
      // arbiter: holder keeps grant while it still requests
      if (!mode_int) begin
        next_st.gnt_n = 4'hF;
        next_st.own_gnt = 1'b0;
      end else if (bus_idle && !((st.gnt_n != 4'hF || st.own_gnt) && reqs[st.rr_ptr])) begin
        next_st.gnt_n = 4'hF;
        next_st.own_gnt = 1'b0;
        for (int i = 1; i <= 5; i++) begin
          slot = {1'b0, st.rr_ptr} + 4'(i);
          if (slot >= {1'b0, ARB_SLOTS}) begin
            slot = slot - {1'b0, ARB_SLOTS};
          end
          if (!found && reqs[slot[2:0]]) begin
            found = 1'b1;
            next_st.rr_ptr = slot[2:0];
            if (slot == 4'h4) begin
              next_st.own_gnt = 1'b1;
            end else begin
              next_st.gnt_n[slot[1:0]] = 1'b0;
            end
          end
        end
      end
      // ==========================================
      // master engine, single data phase
      unique case (st.mst)
        M_IDLE: ;
        M_REQ: begin
          granted = mode_int ? st.own_gnt : ~p.gnt_n[0];
          next_st.req0_o = mode_int;
          if (granted && bus_idle) begin
            next_st.mst = M_ADDR;
            next_st.req0_o = 1'b1;
            next_st.ad_o = st.m_addr;
            next_st.cbe_o = st.m_cmd;
            next_st.frame_o = 1'b0;
            next_st.irdy_o = 1'b1;
            next_st.ad_oe_n = 1'b0;
            next_st.cbe_oe_n = 1'b0;
            next_st.mctl_oe_n = 1'b0;
          end
        end
        M_ADDR: begin
          // only phase is the last; ready at once
          next_st.mst = M_DATA;
          next_st.frame_o = 1'b1;
          next_st.irdy_o = 1'b0;
          next_st.cbe_o = st.m_be_n;
          next_st.ad_o = st.m_data;
          next_st.ad_oe_n = ~st.m_write;
          next_st.m_timer = 3'h0;
        end
        M_DATA: begin
          next_st.m_timer = st.m_timer + 3'h1;
          if (!p.devsel_n && (!p.trdy_n || !p.stop_n)) begin
            xfer = 1'b1;
            next_st.m_retry = p.trdy_n;
            if (!st.m_write && !p.trdy_n) begin
              next_st.m_data = p.ad;
            end
          end else if (p.devsel_n && st.m_timer == MABORT_EDGES) begin
            xfer = 1'b1;
            next_st.m_abort = 1'b1;
          end
          if (xfer) begin
            next_st.mst = M_TURN;
            next_st.irdy_o = 1'b1;
            next_st.ad_oe_n = 1'b1;
            next_st.cbe_oe_n = 1'b1;
          end
        end
        M_TURN: begin
          // initiator ready was driven high for one edge, and frame since the data phase began, before release
          next_st.mst = M_IDLE;
          next_st.mctl_oe_n = 1'b1;
          next_st.m_done = 1'b1;
        end
      endcase
      // ==========================================
      // target engine, one word per transaction then disconnect
      unique case (st.tgt)
        T_IDLE: begin
          if (hit_now) begin
            next_st.tgt = T_SEL;
            next_st.t_addr = p.ad;
            next_st.t_write = (p.cbe_n == CMD_MEM_WRITE);
            next_st.devsel_o = 1'b0;
            next_st.trdy_o = 1'b1;
            next_st.stop_o = 1'b1;
            next_st.tctl_oe_n = 1'b0;
          end
        end
        T_SEL: begin
          next_st.tgt = T_DATA;
          if (tgt_ready_in) begin
            next_st.trdy_o = 1'b0;
            next_st.ad_o = tgt_rdata_in;
            next_st.ad_oe_n = st.t_write;
          end else begin
            next_st.stop_o = 1'b0;
          end
        end
        T_DATA: begin
          if (!p.irdy_n && !st.trdy_o) begin
            next_st.t_wr_pulse = st.t_write;
            next_st.t_rd_pulse = ~st.t_write;
            next_st.t_data = p.ad;
            next_st.t_be_n = p.cbe_n;
          end
          if (p.frame_n && !p.irdy_n) begin
            next_st.tgt = T_TURN;
            next_st.devsel_o = 1'b1;
            next_st.trdy_o = 1'b1;
            next_st.stop_o = 1'b1;
            next_st.ad_oe_n = 1'b1;
          end else if (!p.irdy_n) begin
            next_st.trdy_o = 1'b1;
            next_st.stop_o = 1'b0;
            next_st.ad_oe_n = 1'b1;
          end
        end
        T_TURN: begin
          next_st.tgt = T_IDLE;
          next_st.tctl_oe_n = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================
  // pins
  assign muxed_addr_data_out = st.ad_o;
  assign muxed_addr_data_oe_n_out = st.ad_oe_n;
  assign command_byte_enable_n_out = st.cbe_o;
  assign command_byte_enable_oe_n_out = st.cbe_oe_n;
  assign transaction_frame_n_out = st.frame_o;
  assign transaction_frame_oe_n_out = st.mctl_oe_n;
  assign initiator_ready_n_out = st.irdy_o;
  assign initiator_ready_oe_n_out = st.mctl_oe_n;
  assign target_ready_n_out = st.trdy_o;
  assign target_ready_oe_n_out = st.tctl_oe_n;
  assign target_select_n_out = st.devsel_o;
  assign target_select_oe_n_out = st.tctl_oe_n;
  assign target_stop_n_out = st.stop_o;
  assign target_stop_oe_n_out = st.tctl_oe_n;
  // grants driven by arbiter; spare grants high otherwise
  assign bus_grant_n_out = mode_int ? st.gnt_n : 4'hF;
  assign bus_grant_oe_n_out = mode_int ? 4'h0 : 4'h1;
  // satellite mode keeps request one as an input, it acts as a config select
  assign bus_request_n_out = {3'h7, st.req0_o};
  assign bus_request_oe_n_out = mode_int ? 4'hF : (p.mode == MODE_SAT ? 4'h2 : 4'h0);
  assign mst_busy_out = (st.mst != M_IDLE);
  assign mst_done_out = st.m_done;
  assign mst_retry_out = st.m_retry;
  assign mst_abort_out = st.m_abort;
  assign mst_rdata_out = st.m_data;
  assign tgt_write_out = st.t_wr_pulse;
  assign tgt_read_out = st.t_rd_pulse;
  assign tgt_addr_out = st.t_addr;
  assign tgt_wdata_out = st.t_data;
  assign tgt_be_n_out = st.t_be_n;

  // ==========================================
  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_addr_start;
    rise && st.mst == M_REQ ##1 st.mst == M_ADDR;
  endsequence
  sequence s_tgt_sel;
    rise && st.tgt == T_SEL;
  endsequence

  a_grant_one_hot: assert property (
    $countones(~st.gnt_n) + 32'(st.own_gnt) <= 1)
    else $error("more than one grant asserted");
  a_grant_follows_req: assert property (
    rise && mode_int && bus_idle && st.gnt_n == 4'hF && !st.own_gnt && p.req_n != 4'hF
    && st.mst != M_REQ |=> bus_grant_n_out != 4'hF)
    else $error("request left without grant");
  a_spare_grant_high: assert property (
    !mode_int |-> bus_grant_n_out[3:1] == 3'h7 && bus_grant_oe_n_out[3:1] == 3'h0)
    else $error("unused grant not driven high");
  a_ext_grant_in: assert property (
    rise && p.mode == MODE_HOST_EXT && st.mst == M_REQ && !p.gnt_n[0] && bus_idle
    |=> st.mst == M_ADDR && bus_grant_oe_n_out[0])
    else $error("external grant not honoured");
  a_sat_grant_in: assert property (
    rise && p.mode == MODE_SAT && st.mst == M_REQ && p.gnt_n[0] |=> st.mst == M_REQ)
    else $error("started without satellite grant");
  a_addr_drive: assert property (
    s_addr_start |-> muxed_addr_data_out == st.m_addr && !muxed_addr_data_oe_n_out)
    else $error("address not driven in first frame cycle");
  a_cmd_then_be: assert property (
    s_addr_start |-> command_byte_enable_n_out == st.m_cmd ##[1:40]
    (st.mst == M_DATA && command_byte_enable_n_out == st.m_be_n))
    else $error("command or byte enables wrong");
  a_frame_last: assert property (
    $rose(st.mst == M_DATA) |-> transaction_frame_n_out && $past(transaction_frame_n_out) == 1'b0)
    else $error("frame not negated on last phase");
  a_irdy_data: assert property (
    st.mst == M_DATA |-> !initiator_ready_n_out && !initiator_ready_oe_n_out)
    else $error("initiator ready missing in data phase");
  a_devsel_hit: assert property (
    rise && st.tgt == T_IDLE && hit_now |=> !target_select_n_out && !target_select_oe_n_out)
    else $error("device select missing after decode hit");
  a_pins_on_edge: assert property (
    !rise |=> $stable(transaction_frame_n_out) && $stable(target_select_n_out)
    && $stable(target_ready_n_out))
    else $error("bus pin moved off a bus clock edge");
  a_trdy_ready: assert property (
    s_tgt_sel ##0 tgt_ready_in |=> !target_ready_n_out && target_stop_n_out)
    else $error("target ready not asserted");
  a_stop_retry: assert property (
    s_tgt_sel ##0 !tgt_ready_in |=> !target_stop_n_out && target_ready_n_out)
    else $error("stop not asserted for retry");
  a_req_inputs: assert property (
    mode_int |-> bus_request_oe_n_out == 4'hF)
    else $error("request line driven in internal arbiter mode");
endmodule

//--- pbsg_pkg.sv
// constants and types for the pci bus signalling and grant block
package pbsg_pkg;

  // ==========================================
  // bus modes and commands
  localparam logic [1:0] MODE_HOST_INT = 2'h0;
  localparam logic [1:0] MODE_HOST_EXT = 2'h1;
  localparam logic [1:0] MODE_SAT = 2'h2;
  localparam logic [3:0] CMD_MEM_READ = 4'h6;
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;

  // ==========================================
  // master abort count in bus clock edges, and number of arbiter slots
  localparam logic [2:0] MABORT_EDGES = 3'h5;
  localparam logic [2:0] ARB_SLOTS = 3'h5;

  // ==========================================
  // states and the synchronised pin image
  typedef enum logic [2:0] {M_IDLE, M_REQ, M_ADDR, M_DATA, M_TURN} pbsg_mst_type;
  typedef enum logic [1:0] {T_IDLE, T_SEL, T_DATA, T_TURN} pbsg_tgt_type;

  typedef struct packed {
    logic [1:0] mode;
    logic [31:0] ad;
    logic [3:0] cbe_n;
    logic frame_n;
    logic irdy_n;
    logic trdy_n;
    logic devsel_n;
    logic stop_n;
    logic [3:0] gnt_n;
    logic [3:0] req_n;
  } pbsg_pins_type;

  typedef struct packed {
    pbsg_pins_type sync1;
    pbsg_pins_type sync2;
    logic [2:0] clk_sh;
    logic last_frame_n;
    pbsg_mst_type mst;
    pbsg_tgt_type tgt;
    logic [3:0] gnt_n;
    logic own_gnt;
    logic [2:0] rr_ptr;
    logic [31:0] ad_o;
    logic ad_oe_n;
    logic [3:0] cbe_o;
    logic cbe_oe_n;
    logic frame_o;
    logic irdy_o;
    logic mctl_oe_n;
    logic trdy_o;
    logic devsel_o;
    logic stop_o;
    logic tctl_oe_n;
    logic req0_o;
    logic [31:0] m_addr;
    logic [31:0] m_data;
    logic [3:0] m_cmd;
    logic [3:0] m_be_n;
    logic m_write;
    logic [2:0] m_timer;
    logic m_done;
    logic m_retry;
    logic m_abort;
    logic [31:0] t_addr;
    logic [31:0] t_data;
    logic [3:0] t_be_n;
    logic t_write;
    logic t_wr_pulse;
    logic t_rd_pulse;
  } pbsg_state_type;

  localparam pbsg_state_type ST_RESET = '{
    sync1: '1, sync2: '1, clk_sh: 3'h0, last_frame_n: 1'b1, mst: M_IDLE, tgt: T_IDLE,
    gnt_n: 4'hF, own_gnt: 1'b0, rr_ptr: 3'h0, ad_o: 32'h0, ad_oe_n: 1'b1, cbe_o: 4'hF,
    cbe_oe_n: 1'b1, frame_o: 1'b1, irdy_o: 1'b1, mctl_oe_n: 1'b1, trdy_o: 1'b1,
    devsel_o: 1'b1, stop_o: 1'b1, tctl_oe_n: 1'b1, req0_o: 1'b1, m_addr: 32'h0,
    m_data: 32'h0, m_cmd: 4'h0, m_be_n: 4'hF, m_write: 1'b0, m_timer: 3'h0, m_done: 1'b0,
    m_retry: 1'b0, m_abort: 1'b0, t_addr: 32'h0, t_data: 32'h0, t_be_n: 4'hF,
    t_write: 1'b0, t_wr_pulse: 1'b0, t_rd_pulse: 1'b0};

endpackage

//--- pbsg_agent.sv
// far-side pci agents: external arbiter, target at 8xxxxxxx and a simple master
`timescale 1ns/100ps
module pbsg_agent (
  // link clock and scenario controls
  input wire logic bus_clock_in,
  input wire logic arb_en_in,
  input wire logic retry_in,
  input wire logic go_in,
  input wire logic go_write_in,
  input wire logic [31:0] go_addr_in,
  input wire logic [31:0] go_data_in,
  // resolved bus wires
  input wire logic [31:0] muxed_addr_data_in,
  input wire logic [3:0] command_byte_enable_n_in,
  input wire logic transaction_frame_n_in,
  input wire logic initiator_ready_n_in,
  input wire logic target_ready_n_in,
  input wire logic target_select_n_in,
  input wire logic target_stop_n_in,
  input wire logic [3:0] bus_request_n_in,
  // agent drive
  output logic [31:0] ag_ad_out,
  output logic ag_ad_oe_out,
  output logic [3:0] ag_cbe_n_out,
  output logic ag_mctl_oe_out,
  output logic ag_frame_n_out,
  output logic ag_irdy_n_out,
  output logic ag_tctl_oe_out,
  output logic ag_trdy_n_out,
  output logic ag_sel_n_out,
  output logic ag_stop_n_out,
  output logic ag_gnt0_n_out,
  // what the agent saw
  output logic ag_busy_out,
  output logic ag_stop_seen_out,
  output logic [31:0] ag_addr_out,
  output logic [3:0] ag_cmd_out,
  output logic [3:0] ag_be_n_out,
  output logic [31:0] ag_data_out
);
  import pbsg_pkg::*;
  // ==========================================
  // state
  logic [1:0] tst = 2'h0;
  logic [1:0] mst = 2'h0;
  logic last_frame_n = 1'h1;
  assign ag_busy_out = (mst != 2'h0);
  initial begin
    {ag_ad_oe_out, ag_mctl_oe_out, ag_tctl_oe_out, ag_stop_seen_out} = 4'h0;
    {ag_frame_n_out, ag_irdy_n_out, ag_trdy_n_out, ag_sel_n_out, ag_stop_n_out} = 5'h1F;
    ag_gnt0_n_out = 1'h1;
    ag_ad_out = 32'h0;
    ag_cbe_n_out = 4'hF;
  end
  // ==========================================
  // all on bus clock
  always @(posedge bus_clock_in) begin
    last_frame_n <= transaction_frame_n_in;
    ag_gnt0_n_out <= !arb_en_in || bus_request_n_in[0] || go_in || ag_busy_out;
    case (tst)
      2'h0: begin
        if (last_frame_n && !transaction_frame_n_in && muxed_addr_data_in[31:28] == 4'h8
            && !ag_busy_out) begin
          ag_addr_out <= muxed_addr_data_in;
          ag_cmd_out <= command_byte_enable_n_in;
          ag_sel_n_out <= 1'h0;
          ag_tctl_oe_out <= 1'h1;
          tst <= 2'h1;
        end
      end
      2'h1: begin
        ag_trdy_n_out <= retry_in;
        ag_stop_n_out <= !retry_in;
        ag_ad_out <= go_data_in;
        ag_ad_oe_out <= (ag_cmd_out == CMD_MEM_READ);
        tst <= 2'h2;
      end
      2'h2: begin
        if (!initiator_ready_n_in && (!ag_trdy_n_out || !ag_stop_n_out)) begin
          ag_be_n_out <= command_byte_enable_n_in;
          ag_data_out <= muxed_addr_data_in;
          {ag_sel_n_out, ag_trdy_n_out, ag_stop_n_out} <= 3'h7;
          ag_ad_oe_out <= 1'h0;
          tst <= 2'h3;
        end
      end
      default: begin
        ag_tctl_oe_out <= 1'h0;
        tst <= 2'h0;
      end
    endcase
    case (mst)
      2'h0: begin
        if (go_in && transaction_frame_n_in && initiator_ready_n_in) begin
          ag_frame_n_out <= 1'h0;
          ag_mctl_oe_out <= 1'h1;
          ag_ad_out <= go_addr_in;
          ag_ad_oe_out <= 1'h1;
          ag_cbe_n_out <= go_write_in ? CMD_MEM_WRITE : CMD_MEM_READ;
          mst <= 2'h1;
        end
      end
      2'h1: begin
        ag_frame_n_out <= 1'h1;
        ag_irdy_n_out <= 1'h0;
        ag_cbe_n_out <= 4'h0;
        ag_ad_out <= go_data_in;
        ag_ad_oe_out <= go_write_in;
        mst <= 2'h2;
      end
      2'h2: begin
        if (!target_select_n_in && (!target_ready_n_in || !target_stop_n_in)) begin
          ag_irdy_n_out <= 1'h1;
          ag_ad_oe_out <= 1'h0;
          ag_stop_seen_out <= !target_stop_n_in;
          ag_data_out <= muxed_addr_data_in;
          mst <= 2'h3;
        end
      end
      default: begin
        ag_mctl_oe_out <= 1'h0;
        mst <= 2'h0;
      end
    endcase
  end
endmodule

//--- testbench.sv
// self-checking testbench for the pci signalling and grant block
`timescale 1ns/100ps
module testbench;
  import pbsg_pkg::*;
  // ==========================================
  // signals
  logic sys_clk_in, rst_b_in, bus_clock_in, mst_start_in, mst_write_in, tgt_ready_in;
  logic [1:0] bus_mode_in;
  logic [31:0] mst_addr_in, mst_wdata_in, tgt_base_in, tgt_mask_in, tgt_rdata_in;
  logic [31:0] go_addr_in, go_data_in, muxed_addr_data_out, mst_rdata_out;
  logic [31:0] tgt_addr_out, tgt_wdata_out, ag_ad_out, ag_addr_out, ag_data_out;
  logic [3:0] mst_be_n_in, agent_req_n, command_byte_enable_n_out, bus_grant_n_out;
  logic [3:0] bus_grant_oe_n_out, bus_request_n_out, bus_request_oe_n_out, tgt_be_n_out;
  logic [3:0] ag_cbe_n_out, ag_cmd_out, ag_be_n_out;
  logic arb_en_in, retry_in, go_in, go_write_in, muxed_addr_data_oe_n_out;
  logic command_byte_enable_oe_n_out, transaction_frame_n_out, transaction_frame_oe_n_out;
  logic initiator_ready_n_out, initiator_ready_oe_n_out, target_ready_n_out;
  logic target_ready_oe_n_out, target_select_n_out, target_select_oe_n_out;
  logic target_stop_n_out, target_stop_oe_n_out, mst_busy_out, mst_done_out;
  logic mst_retry_out, mst_abort_out, tgt_write_out, tgt_read_out;
  logic ag_ad_oe_out, ag_mctl_oe_out, ag_frame_n_out, ag_irdy_n_out, ag_tctl_oe_out;
  logic ag_trdy_n_out, ag_sel_n_out, ag_stop_n_out, ag_gnt0_n_out, ag_busy_out;
  logic ag_stop_seen_out;
  logic [31:0] flt = 32'h0;
  int failures = 0;
  int cmp_count = 0;
  // released lines: control pulled up, data shows a moving pattern, not the last value
  wire logic [31:0] muxed_addr_data_in = !muxed_addr_data_oe_n_out ? muxed_addr_data_out
    : ag_ad_oe_out ? ag_ad_out : flt;
  wire logic [3:0] command_byte_enable_n_in = !command_byte_enable_oe_n_out
    ? command_byte_enable_n_out : ag_mctl_oe_out ? ag_cbe_n_out : flt[3:0];
  wire logic transaction_frame_n_in = !transaction_frame_oe_n_out ? transaction_frame_n_out
    : !ag_mctl_oe_out || ag_frame_n_out;
  wire logic initiator_ready_n_in = !initiator_ready_oe_n_out ? initiator_ready_n_out
    : !ag_mctl_oe_out || ag_irdy_n_out;
  wire logic target_ready_n_in = !target_ready_oe_n_out ? target_ready_n_out
    : !ag_tctl_oe_out || ag_trdy_n_out;
  wire logic target_select_n_in = !target_select_oe_n_out ? target_select_n_out
    : !ag_tctl_oe_out || ag_sel_n_out;
  wire logic target_stop_n_in = !target_stop_oe_n_out ? target_stop_n_out
    : !ag_tctl_oe_out || ag_stop_n_out;
  wire logic [3:0] bus_grant_n_in = (bus_grant_n_out & ~bus_grant_oe_n_out)
    | ({3'h7, ag_gnt0_n_out} & bus_grant_oe_n_out);
  wire logic [3:0] bus_request_n_in = (bus_request_n_out & ~bus_request_oe_n_out)
    | (agent_req_n & bus_request_oe_n_out);
  // agents act 6 ns after the bus edge, as a clock-to-out delay
  wire logic ag_clock;
  assign #6 ag_clock = bus_clock_in;
  pbsg_top pbsg_top_i (.*);
  pbsg_agent pbsg_agent_i (.*, .bus_clock_in(ag_clock));
  always @(posedge sys_clk_in) flt <= flt + 32'h3C3C_0001;
  int wr_n = 0, rd_n = 0;
  always @(negedge sys_clk_in) begin
    wr_n <= wr_n + int'(tgt_write_out === 1'h1);
    rd_n <= rd_n + int'(tgt_read_out === 1'h1);
  end
  initial begin
    sys_clk_in = 1'h0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    bus_clock_in = 1'h0;
    #37.3;
    forever #80 bus_clock_in = ~bus_clock_in;
  end
  // ==========================================
  // shared tasks
  task automatic finish_test;
    $display("failures %0d, comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // 0 master done, 1 agent busy, 2 agent idle, 3 any grant
  task automatic await(input int what);
    int n;
    n = 0;
    while (!(what == 0 ? mst_done_out === 1'h1 : what == 1 ? ag_busy_out === 1'h1
        : what == 2 ? ag_busy_out === 1'h0 : bus_grant_n_out !== 4'hF)) begin
      @(negedge sys_clk_in);
      n++;
      if (n > 3000) begin
        failures++;
        finish_test;
      end
    end
  endtask
  task automatic do_reset(input logic [1:0] m);
    @(posedge sys_clk_in);
    rst_b_in <= 1'h0;
    bus_mode_in <= m;
    arb_en_in <= (m != MODE_HOST_INT);
    repeat (4) @(posedge sys_clk_in);
    rst_b_in <= 1'h1;
    repeat (200) @(posedge sys_clk_in);
  endtask
  task automatic mst_op(input logic wr, input logic [31:0] a, d, input logic [3:0] be);
    @(posedge sys_clk_in);
    mst_start_in <= 1'h1;
    mst_write_in <= wr;
    mst_addr_in <= a;
    mst_wdata_in <= d;
    mst_be_n_in <= be;
    @(posedge sys_clk_in);
    mst_start_in <= 1'h0;
    @(negedge sys_clk_in);
    check(32'(mst_busy_out), 32'h1);
    await(0);
    check(32'(mst_busy_out), 32'h0);
  endtask
  task automatic ag_op(input logic wr, input logic [31:0] a, d);
    @(posedge sys_clk_in);
    go_in <= 1'h1;
    go_write_in <= wr;
    go_addr_in <= a;
    go_data_in <= d;
    await(1);
    @(posedge sys_clk_in);
    go_in <= 1'h0;
    await(2);
  endtask
  // ==========================================
  // scenarios
  task automatic t_mst_write;
    check(32'(bus_grant_oe_n_out), 32'h1);
    check(32'(bus_grant_n_out[3:1]), 32'h7);
    check(32'({transaction_frame_n_in, bus_request_n_out}), 32'h1F);
    for (int i = 0; i < 2; i++) begin
      mst_op(1'h1, 32'h8000_0104 + 32'(i * 4), 32'hCAFE_1234 ^ 32'(i), 4'(5 * i));
      check(ag_addr_out, 32'h8000_0104 + 32'(i * 4));
      check(32'(ag_cmd_out), 32'(CMD_MEM_WRITE));
      check(32'(ag_be_n_out), 32'(5 * i));
      check(ag_data_out, 32'hCAFE_1234 ^ 32'(i));
      check(32'({mst_retry_out, mst_abort_out}), 32'h0);
    end
  endtask
  task automatic t_target;
    ag_op(1'h1, 32'h4000_0024, 32'h89AB_CDEF);
    check(tgt_addr_out, 32'h4000_0024);
    check(tgt_wdata_out, 32'h89AB_CDEF);
    check(32'({tgt_be_n_out, ag_stop_seen_out}), 32'h0);
    check(32'(wr_n), 32'h1);
    ag_op(1'h0, 32'h4000_0028, 32'h0);
    check(ag_data_out, 32'h5566_7788);
    check(32'(rd_n), 32'h1);
    @(posedge sys_clk_in);
    tgt_ready_in <= 1'h0;
    ag_op(1'h0, 32'h4000_002C, 32'h0);
    check(32'(ag_stop_seen_out), 32'h1);
    check(32'(wr_n + rd_n), 32'h2);
    @(posedge sys_clk_in);
    tgt_ready_in <= 1'h1;
  endtask
  task automatic t_mst_end;
    retry_in <= 1'h1;
    mst_op(1'h1, 32'h8000_0300, 32'h1111_2222, 4'h0);
    check(32'(mst_retry_out), 32'h1);
    retry_in <= 1'h0;
    mst_op(1'h1, 32'h1000_0000, 32'h3333_4444, 4'h0);
    check(32'({mst_abort_out, mst_retry_out}), 32'h2);
  endtask
  task automatic t_mst_read;
    do_reset(MODE_SAT);
    check(32'(bus_grant_oe_n_out), 32'h1);
    check(32'(bus_grant_n_out[3:1]), 32'h7);
    go_data_in <= 32'h0F1E_2D3C;
    mst_op(1'h0, 32'h8000_0200, 32'h0, 4'h3);
    check(32'(ag_cmd_out), 32'(CMD_MEM_READ));
    check(mst_rdata_out, 32'h0F1E_2D3C);
  endtask
  task automatic t_arbiter;
    do_reset(MODE_HOST_INT);
    check(32'(bus_grant_oe_n_out), 32'h0);
    check(32'(bus_request_oe_n_out), 32'hF);
    agent_req_n <= 4'hB;
    await(3);
    check(32'(bus_grant_n_out), 32'hB);
    @(posedge sys_clk_in);
    agent_req_n <= 4'h5;
    repeat (800) begin
      @(negedge sys_clk_in);
      check(32'($countones(~bus_grant_n_out) < 2), 32'h1);
    end
    check(32'(bus_grant_n_out == 4'hD || bus_grant_n_out == 4'h7), 32'h1);
  endtask
  // ==========================================
  // main sequence
  initial begin
    rst_b_in = 1'h0;
    bus_mode_in = MODE_HOST_EXT;
    {mst_start_in, mst_write_in, go_in, go_write_in, retry_in} = 5'h0;
    {mst_addr_in, mst_wdata_in, go_addr_in, go_data_in} = 128'h0;
    mst_be_n_in = 4'h0;
    agent_req_n = 4'hF;
    arb_en_in = 1'h1;
    tgt_base_in = 32'h4000_0000;
    tgt_mask_in = 32'hFFFF_0000;
    tgt_ready_in = 1'h1;
    tgt_rdata_in = 32'h5566_7788;
    do_reset(MODE_HOST_EXT);
    t_mst_write;
    t_target;
    t_mst_end;
    t_mst_read;
    t_arbiter;
    finish_test;
  end
endmodule
